// ### core/logic_sel_pkg.sv
// shared constants, codes and carriers for the logic table selector
package logic_sel_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int VALUE_W    = 16;   // width of a table value and of a source limit
  localparam int NUM_CAND   = 3;    // candidate tables per logic block
  localparam int SEG_COUNT  = 10;   // segments per lookup table input
  localparam int NUM_POINTS = SEG_COUNT + 1;
  localparam int ADDR_W     = 12;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] ADDR_CTRL       = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_OUT_VALUE  = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_CAND_BASE  = 12'h010;  // one word per candidate
  localparam logic [ADDR_W-1:0] ADDR_LUT_SEL    = 12'h020;
  localparam logic [ADDR_W-1:0] ADDR_LUT_CFG    = 12'h024;
  localparam logic [ADDR_W-1:0] ADDR_ORDER      = 12'h028;
  localparam logic [ADDR_W-1:0] ADDR_POINT_BASE = 12'h040;  // one word per point

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_AUTO_BIT   = 1;
  localparam int STAT_AVAIL_BIT  = 0;
  localparam int STAT_SEL_LSB    = 2;   // two bits, 0 = none, else candidate number
  localparam int STAT_BUSY_BIT   = 4;
  localparam int CAND_COMB_LSB   = 0;   // three bits
  localparam int CAND_LUT_LSB    = 4;   // four bits, lookup table number from 1
  localparam int LCFG_SRC_LSB    = 0;   // four bits, 0 = no input-axis source
  localparam int LCFG_TYPE_BIT   = 4;
  localparam int LCFG_CNT_LSB    = 8;   // four bits, points in use

  // ****************************************************************
  // codes
  // ****************************************************************
  typedef enum logic [2:0] {
    COMB_DEFAULT = 3'h0,
    COMB_ALL_AND = 3'h1,
    COMB_ALL_OR  = 3'h2,
    COMB_AND_OR  = 3'h3,
    COMB_OR_AND  = 3'h4
  } comb_t;

  typedef enum logic [1:0] {
    COND_FALSE = 2'h0,
    COND_TRUE  = 2'h1,
    COND_ERROR = 2'h2,
    COND_NA    = 2'h3
  } cond_t;

  typedef enum logic {
    AXIS_DATA = 1'b0,
    AXIS_TIME = 1'b1
  } axis_t;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [2:0] CAND_COMB_RST [NUM_CAND] = '{3'h1, 3'h1, 3'h0};
  localparam logic [3:0] CAND_LUT_RST  [NUM_CAND] = '{4'h1, 4'h2, 4'h3};
  localparam logic [3:0] LUT_SRC_RST  = 4'h0;
  localparam logic [3:0] LUT_CNT_RST  = 4'hB;
  localparam logic [3:0] LUT_CNT_MIN  = 4'h1;   // point zero can never be ignored

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    cond_t third_condition_result;
    cond_t second_condition_result;
    cond_t first_condition_result;
  } cand_conds_t;

  typedef struct packed {
    logic [VALUE_W-1:0] value;
    logic [VALUE_W-1:0] lowest_input_limit;
    logic [VALUE_W-1:0] highest_input_limit;
  } lut_in_t;

endpackage

// ### core/cand_matcher.sv
// combines the three condition results of one candidate table
`timescale 1ns/1ps
module cand_matcher (
  input  logic_sel_pkg::comb_t       comb_i,
  input  logic_sel_pkg::cand_conds_t conds_i,
  output logic                       match_o
);
  import logic_sel_pkg::*;

  logic c1_true;
  logic c2_true;
  logic c3_true;
  logic c1_pass;
  logic c2_pass;
  logic c3_pass;

  // strict truth: error and n/a both count as false
  assign c1_true = (conds_i.first_condition_result == COND_TRUE);
  assign c2_true = (conds_i.second_condition_result == COND_TRUE);
  assign c3_true = (conds_i.third_condition_result == COND_TRUE);

  assign c1_pass = c1_true || (conds_i.first_condition_result == COND_NA);
  assign c2_pass = c2_true || (conds_i.second_condition_result == COND_NA);
  assign c3_pass = c3_true || (conds_i.third_condition_result == COND_NA);

  // unknown codes never select, so a bad setting cannot hide later tables
  always_comb begin
    unique case (comb_i)
      COMB_DEFAULT: match_o = 1'b1;
      COMB_ALL_AND: match_o = c1_pass && c2_pass && c3_pass;
      COMB_ALL_OR:  match_o = c1_true || c2_true || c3_true;
      COMB_AND_OR:  match_o = (c1_true && c2_true) || c3_true;
      COMB_OR_AND:  match_o = (c1_true || c2_true) && c3_true;
      default:      match_o = 1'b0;
    endcase
  end
endmodule

// ### core/logic_table_selector.sv
// table selection stage of a programmable logic block with its lookup table axes
`timescale 1ns/1ps
module logic_table_selector #(
  parameter int NUM_LUT = 8
) (
  input  wire logic                                       clk_sys_i,
  input  wire logic                                       reset_n_i,
  input  wire logic [logic_sel_pkg::ADDR_W-1:0]           paddr_i,
  input  wire logic                                       psel_i,
  input  wire logic                                       penable_i,
  input  wire logic                                       pwrite_i,
  input  wire logic [31:0]                                pwdata_i,
  output logic      [31:0]                                prdata_o,
  output logic                                            pready_o,
  output logic                                            pslverr_o,
  input  wire logic_sel_pkg::cand_conds_t [logic_sel_pkg::NUM_CAND-1:0] conds_i,
  input  wire logic_sel_pkg::lut_in_t     [NUM_LUT-1:0]   lut_i,
  output logic      [logic_sel_pkg::VALUE_W-1:0]          logic_value_o,
  output logic                                            logic_avail_o,
  output logic      [1:0]                                 selected_table_o
);
  import logic_sel_pkg::*;

  localparam int LI_W = $clog2(NUM_LUT);

  // the lookup table number field is four bits and counts from one
  if (NUM_LUT < 2 || NUM_LUT > 15) begin : g_num_lut_check
    $error("NUM_LUT must lie in 2..15");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FILL  = 2'b01,
    ST_CHECK = 2'b10
  } walk_t;

  logic                 enable_q;
  logic                 auto_q;
  comb_t                cand_comb_q [NUM_CAND];
  logic [3:0]           cand_lut_q  [NUM_CAND];
  logic [LI_W-1:0]      lut_sel_q;
  logic [3:0]           lut_src_q   [NUM_LUT];
  axis_t                lut_type_q  [NUM_LUT];
  logic [3:0]           lut_cnt_q   [NUM_LUT];
  logic [VALUE_W-1:0]   point_q     [NUM_LUT][NUM_POINTS];
  logic [VALUE_W-1:0]   low_prev_q  [NUM_LUT];
  logic [VALUE_W-1:0]   high_prev_q [NUM_LUT];
  logic [NUM_LUT-1:0]   fill_req_q;
  logic [NUM_LUT-1:0]   order_ok_q;
  walk_t                walk_q;
  logic [LI_W-1:0]      walk_lut_q;
  logic [3:0]           walk_pt_q;
  logic                 chk_ok_q;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic                 acc;
  logic                 wr_en;
  logic [ADDR_W-1:0]    pt_off;
  logic [3:0]           pt_idx;
  logic                 is_point;
  logic                 is_cand;
  logic [1:0]           cand_idx;
  logic                 mapped;

  assign acc      = psel_i && penable_i;
  assign wr_en    = acc && pwrite_i && pready_o && !pslverr_o;
  assign pt_off   = paddr_i - ADDR_POINT_BASE;
  assign pt_idx   = pt_off[5:2];
  assign is_point = (paddr_i >= ADDR_POINT_BASE) && (pt_off[ADDR_W-1:6] == '0)
                    && (pt_idx < 4'(NUM_POINTS));
  assign cand_idx = 2'((paddr_i - ADDR_CAND_BASE) >> 2);
  assign is_cand  = (paddr_i >= ADDR_CAND_BASE) && (paddr_i < ADDR_LUT_SEL)
                    && (cand_idx < 2'(NUM_CAND));
  assign mapped   = (paddr_i[1:0] == 2'b00) && (is_point || is_cand
                    || paddr_i == ADDR_CTRL || paddr_i == ADDR_STATUS
                    || paddr_i == ADDR_OUT_VALUE || paddr_i == ADDR_LUT_SEL
                    || paddr_i == ADDR_LUT_CFG || paddr_i == ADDR_ORDER);

  // a lookup table number outside 1..NUM_LUT names no table
  function automatic logic lut_no_ok(input logic [3:0] no);
    return (no != 4'h0) && (no <= 4'(NUM_LUT));
  endfunction

  // ****************************************************************
  // bus answer: one wait cycle so data and strobe come from flops
  // ****************************************************************
  logic [31:0] rdata;

  always_comb begin
    rdata = 32'h0000_0000;
    if (is_point) begin
      rdata[VALUE_W-1:0] = point_q[lut_sel_q][pt_idx];
    end else if (is_cand) begin
      rdata[CAND_COMB_LSB +: 3] = cand_comb_q[cand_idx];
      rdata[CAND_LUT_LSB +: 4]  = cand_lut_q[cand_idx];
    end else if (paddr_i == ADDR_CTRL) begin
      rdata[CTRL_ENABLE_BIT] = enable_q;
      rdata[CTRL_AUTO_BIT]   = auto_q;
    end else if (paddr_i == ADDR_STATUS) begin
      rdata[STAT_AVAIL_BIT]     = logic_avail_o;
      rdata[STAT_SEL_LSB +: 2]  = selected_table_o;
      rdata[STAT_BUSY_BIT]      = (walk_q == ST_FILL) || (fill_req_q != '0);
    end else if (paddr_i == ADDR_OUT_VALUE) begin
      rdata[VALUE_W-1:0] = logic_value_o;
    end else if (paddr_i == ADDR_LUT_SEL) begin
      rdata[LI_W-1:0] = lut_sel_q;
    end else if (paddr_i == ADDR_LUT_CFG) begin
      rdata[LCFG_SRC_LSB +: 4] = lut_src_q[lut_sel_q];
      rdata[LCFG_TYPE_BIT]     = lut_type_q[lut_sel_q];
      rdata[LCFG_CNT_LSB +: 4] = lut_cnt_q[lut_sel_q];
    end else if (paddr_i == ADDR_ORDER) begin
      rdata[NUM_LUT-1:0] = order_ok_q;
    end
  end

  // ready rises in the second access cycle and falls after the handshake
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= acc && !pready_o;
      pslverr_o <= acc && !pready_o && !mapped;
      if (acc && !pready_o) begin
        prdata_o <= mapped ? rdata : 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // control and candidate registers
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      enable_q  <= 1'b0;
      auto_q    <= 1'b0;
      lut_sel_q <= '0;
      for (int c = 0; c < NUM_CAND; c++) begin
        cand_comb_q[c] <= comb_t'(CAND_COMB_RST[c]);
        cand_lut_q[c]  <= CAND_LUT_RST[c];
      end
    end else if (wr_en) begin
      if (paddr_i == ADDR_CTRL) begin
        enable_q <= pwdata_i[CTRL_ENABLE_BIT];
        auto_q   <= pwdata_i[CTRL_AUTO_BIT];
      end
      if (paddr_i == ADDR_LUT_SEL) begin
        lut_sel_q <= pwdata_i[LI_W-1:0];
      end
      if (is_cand) begin
        cand_comb_q[cand_idx] <= comb_t'(pwdata_i[CAND_COMB_LSB +: 3]);
        cand_lut_q[cand_idx]  <= pwdata_i[CAND_LUT_LSB +: 4];
      end
    end
  end

  // ****************************************************************
  // lookup table axis configuration
  // ****************************************************************
  logic cfg_wr;
  logic [3:0] new_cnt;

  assign cfg_wr  = wr_en && (paddr_i == ADDR_LUT_CFG);
  // clamp keeps point zero live and caps at ten segments
  assign new_cnt = (pwdata_i[LCFG_CNT_LSB +: 4] < LUT_CNT_MIN) ? LUT_CNT_MIN :
                   (pwdata_i[LCFG_CNT_LSB +: 4] > LUT_CNT_RST) ? LUT_CNT_RST :
                   pwdata_i[LCFG_CNT_LSB +: 4];

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      for (int l = 0; l < NUM_LUT; l++) begin
        lut_src_q[l]  <= LUT_SRC_RST;
        lut_type_q[l] <= AXIS_DATA;
        lut_cnt_q[l]  <= LUT_CNT_RST;
      end
    end else if (cfg_wr) begin
      lut_src_q[lut_sel_q]  <= pwdata_i[LCFG_SRC_LSB +: 4];
      lut_type_q[lut_sel_q] <= axis_t'(pwdata_i[LCFG_TYPE_BIT]);
      lut_cnt_q[lut_sel_q]  <= new_cnt;
    end
  end

  // limit history, compared each cycle to spot a source limit change
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      for (int l = 0; l < NUM_LUT; l++) begin
        low_prev_q[l]  <= '0;
        high_prev_q[l] <= '0;
      end
    end else begin
      for (int l = 0; l < NUM_LUT; l++) begin
        low_prev_q[l]  <= lut_i[l].lowest_input_limit;
        high_prev_q[l] <= lut_i[l].highest_input_limit;
      end
    end
  end

  // refill requests: a new request in the cycle its bit is taken wins
  logic [NUM_LUT-1:0] fill_set;
  logic [NUM_LUT-1:0] fill_clr;

  always_comb begin
    for (int l = 0; l < NUM_LUT; l++) begin
      // auto-update on source or limit change
      fill_set[l] = auto_q && (lut_src_q[l] != LUT_SRC_RST)
                    && (lut_i[l].lowest_input_limit != low_prev_q[l]
                        || lut_i[l].highest_input_limit != high_prev_q[l]);
      if (cfg_wr && (LI_W'(l) == lut_sel_q)) begin
        if (auto_q && pwdata_i[LCFG_SRC_LSB +: 4] != lut_src_q[l]) begin
          fill_set[l] = 1'b1;
        end
        if (pwdata_i[LCFG_TYPE_BIT] != lut_type_q[l]) begin
          fill_set[l] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      fill_req_q <= '0;
    end else begin
      fill_req_q <= (fill_req_q & ~fill_clr) | fill_set;
    end
  end

  // ****************************************************************
  // point walker: refills tables and scans them for order
  // ****************************************************************
  logic [LI_W-1:0]    first_req;
  logic [VALUE_W-1:0] w_low;
  logic [VALUE_W-1:0] w_high;
  logic [VALUE_W-1:0] span;
  logic [VALUE_W+3:0] prod;
  logic [VALUE_W-1:0] fill_val;
  logic [VALUE_W-1:0] cur_pt;
  logic               step_ok;

  always_comb begin
    first_req = '0;
    for (int l = NUM_LUT - 1; l >= 0; l--) begin
      if (fill_req_q[l]) begin
        first_req = LI_W'(l);
      end
    end
  end

  assign fill_clr = (walk_q == ST_IDLE && fill_req_q != '0) ?
                    (NUM_LUT'(1) << first_req) : '0;

  // range taken from the source limits
  assign w_low  = lut_i[walk_lut_q].lowest_input_limit;
  assign w_high = lut_i[walk_lut_q].highest_input_limit;
  // inverted limits collapse every default point onto the low limit
  assign span     = (w_high > w_low) ? (w_high - w_low) : '0;
  assign prod     = span * walk_pt_q;
  assign fill_val = w_low + VALUE_W'(prod / (VALUE_W+4)'(SEG_COUNT));
  assign cur_pt   = point_q[walk_lut_q][walk_pt_q];
  assign step_ok  = (cur_pt <= w_high) && ((walk_pt_q == 4'h0) ? (w_low <= cur_pt)
                    : (point_q[walk_lut_q][walk_pt_q - 4'h1] <= cur_pt));

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      walk_q     <= ST_IDLE;
      walk_lut_q <= '0;
      walk_pt_q  <= 4'h0;
      chk_ok_q   <= 1'b1;
      order_ok_q <= '0;
    end else begin
      unique case (walk_q)
        ST_IDLE: begin
          walk_pt_q <= 4'h0;
          chk_ok_q  <= 1'b1;
          if (fill_req_q != '0) begin
            walk_lut_q <= first_req;
            walk_q     <= ST_FILL;
          end else begin
            walk_lut_q <= '0;
            walk_q     <= ST_CHECK;
          end
        end
        ST_FILL: begin
          walk_pt_q <= walk_pt_q + 4'h1;
          if (walk_pt_q == 4'(SEG_COUNT)) begin
            walk_q <= ST_IDLE;
          end
        end
        ST_CHECK: begin
          // only points in use are checked
          if (walk_pt_q >= lut_cnt_q[walk_lut_q]) begin
            order_ok_q[walk_lut_q] <= chk_ok_q;
            chk_ok_q               <= 1'b1;
            walk_pt_q              <= 4'h0;
            walk_lut_q             <= walk_lut_q + LI_W'(1);
            if (walk_lut_q == LI_W'(NUM_LUT - 1) || fill_req_q != '0) begin
              walk_q <= ST_IDLE;
            end
          end else begin
            chk_ok_q  <= chk_ok_q && step_ok;
            walk_pt_q <= walk_pt_q + 4'h1;
          end
        end
        default: walk_q <= ST_IDLE;
      endcase
    end
  end

  // point storage; software writes are dropped while a refill runs
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      for (int l = 0; l < NUM_LUT; l++) begin
        for (int p = 0; p < NUM_POINTS; p++) begin
          point_q[l][p] <= '0;
        end
      end
    end else if (walk_q == ST_FILL) begin
      // defaults spread evenly over the limits
      point_q[walk_lut_q][walk_pt_q] <= fill_val;
    end else if (wr_en && is_point) begin
      // any value accepted, no ordering enforced
      point_q[lut_sel_q][pt_idx] <= pwdata_i[VALUE_W-1:0];
    end
  end

  // ****************************************************************
  // candidate evaluation and output
  // ****************************************************************
  logic [NUM_CAND-1:0] match;

  generate
    for (genvar c = 0; c < NUM_CAND; c++) begin : g_cand
      cand_matcher u_match (
        .comb_i  (cand_comb_q[c]),
        .conds_i (conds_i[c]),
        .match_o (match[c])
      );
    end
  endgenerate

  logic               found;
  logic [1:0]         sel_idx;
  logic [3:0]         sel_lut;
  logic [LI_W-1:0]    sel_li;

  always_comb begin
    found   = 1'b0;
    sel_idx = 2'b00;
    for (int c = 0; c < NUM_CAND; c++) begin
      if (!found && match[c]) begin
        found   = 1'b1;
        sel_idx = 2'(c);
      end
    end
  end

  assign sel_lut = cand_lut_q[sel_idx];
  assign sel_li  = LI_W'(sel_lut - 4'h1);

  // output registered so a downstream block sees one clean value per cycle
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      logic_value_o    <= '0;
      logic_avail_o    <= 1'b0;
      selected_table_o <= 2'b00;
    end else if (!enable_q || !found) begin
      logic_value_o    <= '0;
      logic_avail_o    <= 1'b0;
      selected_table_o <= 2'b00;
    end else begin
      selected_table_o <= sel_idx + 2'b01;
      if (!lut_no_ok(sel_lut) || lut_src_q[sel_li] == LUT_SRC_RST) begin
        logic_value_o <= '0;
        logic_avail_o <= 1'b0;
      end else begin
        logic_value_o <= lut_i[sel_li].value;
        logic_avail_o <= 1'b1;
      end
    end
  end

endmodule

// ### testbench/lts_sva.sv
// port assertions for the logic table selector
`timescale 1ns/1ps
module lts_sva (
  input wire logic        clk_sys_i,
  input wire logic        reset_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [15:0] logic_value_o,
  input wire logic        logic_avail_o,
  input wire logic [1:0]  selected_table_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready too long");
  a_access_answer: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("no ready one cycle after access");
  a_ready_idle: assert property (!(psel_i && penable_i) |=> !pready_o)
    else $error("ready without access");
  a_slverr_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  a_rdata_hold: assert property (!pready_o |-> $stable(prdata_o)) else $error("rdata moved");
  a_none_unavail: assert property (selected_table_o == 2'h0 |-> !logic_avail_o)
    else $error("output available with no table");
  a_unavail_zero: assert property (!logic_avail_o |-> logic_value_o == 16'h0000)
    else $error("value shown while not available");
  a_avail_sel: assert property (logic_avail_o |-> selected_table_o != 2'h0)
    else $error("available without selection");
endmodule
bind logic_table_selector lts_sva u_sva (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .logic_value_o(logic_value_o), .logic_avail_o(logic_avail_o),
  .selected_table_o(selected_table_o));

// ### testbench/far_side_model.sv
// behavioural lookup tables and their source limits facing the selector
`timescale 1ns/1ps
module far_side_model #(
  parameter int NUM_LUT = 4
) (
  output logic_sel_pkg::lut_in_t [NUM_LUT-1:0] lut_o,
  input  wire logic                            wide_i
);
  import logic_sel_pkg::*;
  always_comb begin
    for (int i = 0; i < NUM_LUT; i++) begin
      lut_o[i].value = 16'hA001 + VALUE_W'(i);  // distinct per table
      lut_o[i].lowest_input_limit = 16'h0010;
      // a wider source range stands in for a limit change
      lut_o[i].highest_input_limit = wide_i ? 16'h0150 : 16'h00B0;
    end
  end
endmodule

// ### testbench/logic_table_selector_bench.sv
// self-checking bench for the logic table selector
`timescale 1ns/1ps
module logic_table_selector_bench;
  import logic_sel_pkg::*;
  logic                       clk_sys_i = 0, reset_n_i = 0, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0]          paddr = '0;
  logic [31:0]                pwdata = '0, prdata_o, rd;
  logic                       pready_o, pslverr_o, avail, err;
  logic [VALUE_W-1:0]         value;
  logic [1:0]                 sel, e;
  cand_conds_t [NUM_CAND-1:0] conds = '0;
  lut_in_t [3:0]              lut;
  logic                       wide = 0;
  int                         failures = 0, n_compared = 0;
  logic [31:0]                rst_exp [3] = '{32'h11, 32'h21, 32'h30};
  initial forever #25 clk_sys_i = ~clk_sys_i;
  logic_table_selector #(.NUM_LUT(4)) uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .conds_i(conds), .lut_i(lut), .logic_value_o(value), .logic_avail_o(avail),
    .selected_table_o(sel));
  far_side_model #(.NUM_LUT(4)) partner (.lut_o(lut), .wide_i(wide));
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one apb transfer; request held until ready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk_sys_i);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (pready_o !== 1'b1 && k < 16);
    rd = prdata_o;
    err = pslverr_o;
    {psel, penable} <= 2'b00;
    if (k >= 16) begin
      failures++;
      conclude();
    end
  endtask
  // poll the busy flag until every pending refill is done; bounded
  task automatic settle;
    int n;
    n = 0;
    do begin
      apb(0, ADDR_STATUS, 0);
      n++;
    end while (rd[STAT_BUSY_BIT] && n < 40);
    chk(n < 40, 1);
  endtask
  // conditions of candidate one, then wait out the one-cycle latency
  task automatic drive(input logic [5:0] p);
    @(posedge clk_sys_i);
    conds[0] <= cand_conds_t'(p);
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask
  function automatic logic m(input int c, input logic [5:0] p);
    logic t1, t2, t3;
    t1 = p[1:0] == 2'h1;
    t2 = p[3:2] == 2'h1;
    t3 = p[5:4] == 2'h1;
    case (c)
      1: m = p[0] && p[2] && p[4];  // true or n/a both have bit 0 set
      2: m = t1 | t2 | t3;
      3: m = t1 & t2 | t3;
      4: m = (t1 | t2) & t3;
      default: m = 1'b0;
    endcase
  endfunction
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      apb(0, ADDR_CAND_BASE + 12'(4 * k), 0);
      chk(rd, rst_exp[k]);
    end
    apb(0, ADDR_LUT_CFG, 0);
    chk(rd, 32'h0000_0B00);
    apb(0, 12'h0FC, 0);
    chk(rd | {err, 31'h0}, 32'h8000_0000);
    apb(1, ADDR_CTRL, 1);
    drive(6'h00);
    chk({sel, avail, value}, {2'h3, 1'b0, 16'h0});
    apb(0, ADDR_STATUS, 0);
    chk(rd, 32'h0000_000C);
    for (int k = 0; k < 3; k++) begin
      apb(1, ADDR_LUT_SEL, k);
      apb(1, ADDR_LUT_CFG, 32'h0B01);
    end
    apb(1, ADDR_CAND_BASE + 12'h4, 32'h25);
    // codes 1 to 5 against every condition pattern; misses fall to the default
    for (int c = 1; c < 6; c++) begin
      apb(1, ADDR_CAND_BASE, 32'h10 | c);
      for (int p = 0; p < 64; p++) begin
        drive(6'(p));
        e = m(c, 6'(p)) ? 2'h1 : 2'h3;
        chk({sel, avail, value}, {e, 1'b1, 16'hA000 + 16'(e)});
      end
    end
    apb(0, ADDR_OUT_VALUE, 0);
    chk(rd, 32'h0000_A003);
    apb(1, ADDR_CAND_BASE + 12'h8, 32'h35);
    drive(6'h00);
    chk({sel, avail, value}, 0);
    apb(1, ADDR_LUT_SEL, 0);
    apb(1, ADDR_LUT_CFG, 32'h0B11);
    settle();
    // a full scan of all tables takes about fifty cycles
    repeat (110) @(posedge clk_sys_i);
    apb(0, ADDR_ORDER, 0);
    chk(rd, 32'h0000_0001);
    apb(0, ADDR_POINT_BASE + 12'h28, 0);
    chk(rd, 32'h00B0);
    apb(0, ADDR_POINT_BASE + 12'h14, 0);
    chk(rd, 32'h0060);
    apb(1, ADDR_POINT_BASE + 12'h0C, 32'hFFFF);
    apb(0, ADDR_POINT_BASE + 12'h0C, 0);
    chk(rd, 32'hFFFF);
    repeat (110) @(posedge clk_sys_i);
    apb(0, ADDR_ORDER, 0);
    chk(rd, 32'h0000_0000);
    // three points in use leave the bad point three out of the scan
    apb(1, ADDR_LUT_CFG, 32'h0311);
    repeat (110) @(posedge clk_sys_i);
    apb(0, ADDR_ORDER, 0);
    chk(rd, 32'h0000_0001);
    // auto-update: a new source, then a limit change, refill the points
    apb(1, ADDR_CTRL, 3);
    apb(1, ADDR_LUT_SEL, 3);
    apb(1, ADDR_LUT_CFG, 32'h0B02);
    settle();
    apb(0, ADDR_POINT_BASE + 12'h28, 0);
    chk(rd, 32'h00B0);
    wide <= 1'b1;
    settle();
    apb(0, ADDR_POINT_BASE + 12'h28, 0);
    chk(rd, 32'h0150);
    conclude();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    conclude();
  end
endmodule
